// ===== include/gfx_pkg.sv
// Constants and carrier types for the planar graphics write/read unit.
// Assumes a 16-bit I/O port space and four 8-bit display memory planes.
package gfx_pkg;

    // ****************************************************************
    // I/O ports and register indices
    // ****************************************************************
    localparam logic [15:0] INDEX_PORT_ADDR = 16'h03ce;   // Index port address.
    localparam logic [15:0] DATA_PORT_ADDR  = 16'h03cf;   // Data port address.
    localparam logic [3:0]  IDX_FILL_VALUE  = 4'h0;       // Fill colour value.
    localparam logic [3:0]  IDX_FILL_ENABLE = 4'h1;       // Fill colour enable.
    localparam logic [3:0]  IDX_CMP_COLOUR  = 4'h2;       // Compare reference colour.
    localparam logic [3:0]  IDX_LOGIC_ROT   = 4'h3;       // Logic op and rotation.
    localparam logic [3:0]  IDX_PLANE_READ  = 4'h4;       // Plane read choice.
    localparam logic [3:0]  IDX_ACCESS_CTL  = 4'h5;       // Planar access control.
    localparam logic [3:0]  IDX_CMP_IGNORE  = 4'h7;       // Compare plane ignore.
    localparam logic [3:0]  IDX_BIT_MASK    = 4'h8;       // Bit mask.

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int ROT_LSB      = 0;     // Rotate count low bit.
    localparam int LOP_LSB      = 3;     // Logical operation low bit.
    localparam int WMODE_LSB    = 0;     // Write mode low bit.
    localparam int RCMP_BIT     = 3;     // Compare read enable bit.
    localparam int ODDEVEN_BIT  = 4;     // Odd/even addressing bit.
    localparam int SHOE_BIT     = 5;     // Odd/even shift bit.
    localparam int SH256_BIT    = 6;     // 256-colour shift bit.
    localparam logic [7:0] REG_RESET = 8'h00;  // Defined reset value of every register.
    localparam logic [7:0] MASK4     = 8'h0f;  // Writable bits of 4-bit registers.
    localparam logic [7:0] MASK_LR   = 8'h1f;  // Writable bits of logic/rotate.
    localparam logic [7:0] MASK_PR   = 8'h03;  // Writable bits of plane read choice.
    localparam logic [7:0] MASK_AC   = 8'h7b;  // Writable bits of access control.

    // ****************************************************************
    // Enumerations and carriers
    // ****************************************************************
    typedef enum logic [1:0] {
        LOP_PASS = 2'b00,
        LOP_AND  = 2'b01,
        LOP_OR   = 2'b10,
        LOP_XOR  = 2'b11
    } lop_type;

    typedef enum logic [1:0] {
        WM_0 = 2'b00,
        WM_1 = 2'b01,
        WM_2 = 2'b10,
        WM_3 = 2'b11
    } wmode_type;

    // One 8-bit byte for each of four planes.
    typedef struct packed {
        logic [7:0] p3;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } planes_type;

    // Processor display memory cycle request.
    typedef struct packed {
        logic       rd;      // Read strobe.
        logic       wr;      // Write strobe.
        logic       a0;      // Lowest address bit.
        logic [7:0] data;    // Write data.
    } mem_req_type;

endpackage : gfx_pkg

// ===== core/gfx_rotate.sv
// Rotates one byte right by a 3-bit count.
// Pure combinational, used by the write path of the graphics unit.
`timescale 1ns/1ps
`default_nettype none
module gfx_rotate (
    // Data in and count.
    input  wire logic [7:0] din,
    input  wire logic [2:0] count,
    // Rotated data.
    output logic [7:0]      dout
);
    // Doubled byte lets a plain shift implement the rotation.
    wire [15:0] doubled = {din, din};
    wire [15:0] shifted = doubled >> count;

    // Low byte of the shifted pair is the rotated byte; zero count passes data.
    assign dout = shifted[7:0];
endmodule // gfx_rotate
`default_nettype wire

// ===== core/gfx_unit.sv
// Planar graphics write/read unit: index/data register pair, four write
// modes, two read modes, odd/even addressing and shifter load controls.
// Assumes the host presents I/O and memory cycles as one-cycle strobes on
// clk_sys, and that display memory returns all four planes combinationally.
//
// Behaviour
// - index port selects register reached through data port
// - index holds four bits, upper bits read zero
// - fill value bit replicated across plane byte
// - mode 0 enable picks fill or data
// - read mode 1 returns colour match bits
// - rotate write byte right by count
// - logic op with latches, never mode 1
// - plane selector for read mode 0
// - mode 0 rotate, fill, logic, mask
// - mode 1 writes latches unchanged
// - processor reads load the four latches
// - mode 2 data bits become plane colour
// - mode 3 fill colour, rotated data masks
// - compare enable bit selects read mode
// - odd/even addressing splits planes by A0
// - odd/even shift interleaves plane pair bits
// - 256-colour shift overrides odd/even shift
// - data port carries full eight bits
// - zero mask bit keeps latched value
// - compare ignore zero excludes plane
`timescale 1ns/1ps
`default_nettype none
module gfx_unit (
    // Clock and reset.
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // I/O port cycles.
    input  wire logic                io_wr,
    input  wire logic                io_rd,
    input  wire logic [15:0]         io_addr,
    input  wire logic [7:0]          io_wdata,
    output logic [7:0]               io_rdata,
    // Display memory cycles from the processor.
    input  wire gfx_pkg::mem_req_type mem_req,
    output logic [7:0]               mem_rdata,
    // Plane memory port.
    input  wire gfx_pkg::planes_type plane_rd,
    output gfx_pkg::planes_type      plane_wr,
    output logic [3:0]               plane_we,
    // Shifter load controls.
    output logic                     shift_odd_even,
    output logic                     shift_256
);
    import gfx_pkg::*;

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [3:0] index_r;          // Register index field.
    logic [7:0] fill_value_r;     // Fill colour value.
    logic [7:0] fill_enable_r;    // Fill colour enable.
    logic [7:0] cmp_colour_r;     // Compare reference colour.
    logic [7:0] logic_rot_r;      // Logic op and rotation.
    logic [7:0] plane_read_r;     // Plane read choice.
    logic [7:0] access_ctl_r;     // Planar access control.
    logic [7:0] cmp_ignore_r;     // Compare plane ignore.
    logic [7:0] bit_mask_r;       // Bit mask.
    planes_type latch_r;          // Per-plane processor latches.

    // Port decode as named wires.
    wire index_sel = (io_addr == INDEX_PORT_ADDR);
    wire data_sel  = (io_addr == DATA_PORT_ADDR);
    wire data_wr   = io_wr && data_sel;
    wire wr_fv     = data_wr && (index_r == IDX_FILL_VALUE);
    wire wr_fe     = data_wr && (index_r == IDX_FILL_ENABLE);
    wire wr_cc     = data_wr && (index_r == IDX_CMP_COLOUR);
    wire wr_lr     = data_wr && (index_r == IDX_LOGIC_ROT);
    wire wr_pr     = data_wr && (index_r == IDX_PLANE_READ);
    wire wr_ac     = data_wr && (index_r == IDX_ACCESS_CTL);
    wire wr_ci     = data_wr && (index_r == IDX_CMP_IGNORE);
    wire wr_bm     = data_wr && (index_r == IDX_BIT_MASK);

    // Index register; only the low four bits are stored.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            index_r <= 4'h0;
        end else if (io_wr && index_sel) begin
            index_r <= io_wdata[3:0];
        end
    end

    // Data registers; reserved bits are masked so they read back zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fill_value_r  <= REG_RESET;
            fill_enable_r <= REG_RESET;
            cmp_colour_r  <= REG_RESET;
            logic_rot_r   <= REG_RESET;
            plane_read_r  <= REG_RESET;
            access_ctl_r  <= REG_RESET;
            cmp_ignore_r  <= REG_RESET;
            bit_mask_r    <= REG_RESET;
        end else begin
            if (wr_fv) fill_value_r  <= io_wdata & MASK4;
            if (wr_fe) fill_enable_r <= io_wdata & MASK4;
            if (wr_cc) cmp_colour_r  <= io_wdata & MASK4;
            if (wr_lr) logic_rot_r   <= io_wdata & MASK_LR;
            if (wr_pr) plane_read_r  <= io_wdata & MASK_PR;
            if (wr_ac) access_ctl_r  <= io_wdata & MASK_AC;
            if (wr_ci) cmp_ignore_r  <= io_wdata & MASK4;
            if (wr_bm) bit_mask_r    <= io_wdata;
        end
    end

    // ****************************************************************
    // Register read-back
    // ****************************************************************
    logic [7:0] data_mux;   // Value of the indexed register.

    // Selects the indexed register; unused indices read zero.
    always_comb begin
        unique case (index_r)
            IDX_FILL_VALUE:  data_mux = fill_value_r;
            IDX_FILL_ENABLE: data_mux = fill_enable_r;
            IDX_CMP_COLOUR:  data_mux = cmp_colour_r;
            IDX_LOGIC_ROT:   data_mux = logic_rot_r;
            IDX_PLANE_READ:  data_mux = plane_read_r;
            IDX_ACCESS_CTL:  data_mux = access_ctl_r;
            IDX_CMP_IGNORE:  data_mux = cmp_ignore_r;
            IDX_BIT_MASK:    data_mux = bit_mask_r;
            default:         data_mux = 8'h00;
        endcase
    end

    wire [7:0] io_rd_nxt = index_sel ? {4'h0, index_r} :
                           data_sel  ? data_mux : 8'h00;

    // Read data is registered: it appears the cycle after io_rd.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            io_rdata <= io_rd_nxt;
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************
    wire [2:0]  rot_count  = logic_rot_r[ROT_LSB +: 3];
    wire [1:0]  lop_bits   = logic_rot_r[LOP_LSB +: 2];
    lop_type    lop;
    wmode_type  wmode;
    assign lop   = lop_type'(lop_bits);
    assign wmode = wmode_type'(access_ctl_r[WMODE_LSB +: 2]);
    wire        read_cmp   = access_ctl_r[RCMP_BIT];
    wire        odd_even   = access_ctl_r[ODDEVEN_BIT];
    // Shifter: the 256-colour bit wins, else odd/even shift governs.
    assign shift_256       = access_ctl_r[SH256_BIT];
    assign shift_odd_even  = !access_ctl_r[SH256_BIT] &&
                             access_ctl_r[SHOE_BIT];

    // ****************************************************************
    // Write path
    // ****************************************************************
    logic [7:0] rot_data;   // Rotated processor byte.

    gfx_rotate u_rotate (
        .din   (mem_req.data),
        .count (rot_count),
        .dout  (rot_data)
    );

    // Effective per-pixel mask: mode 3 ANDs rotated data into it.
    wire [7:0] eff_mask = (wmode == WM_3) ? (rot_data & bit_mask_r)
                                          : bit_mask_r;
    wire [31:0] latch_w = latch_r;
    logic [31:0] wr_bus;    // Per-plane merged result.

    // One write lane per plane: source, logic op, then mask merge.
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_plane
            wire [7:0] lat  = latch_w[gp*8 +: 8];
            wire [7:0] fill = {8{fill_value_r[gp]}};
            // Mode 0 substitutes fill where enabled; 2 uses data bits.
            wire [7:0] src  =
                (wmode == WM_2) ? {8{mem_req.data[gp]}} :
                (wmode == WM_3) ? fill :
                fill_enable_r[gp] ? fill : rot_data;
            // Logical operation with the latch, after substitution.
            wire [7:0] opd  =
                (lop == LOP_AND) ? (src & lat) :
                (lop == LOP_OR)  ? (src | lat) :
                (lop == LOP_XOR) ? (src ^ lat) : src;
            // Mask merge last; mode 1 bypasses all of it.
            assign wr_bus[gp*8 +: 8] = (wmode == WM_1) ? lat :
                (opd & eff_mask) | (lat & ~eff_mask);
        end
    endgenerate

    assign plane_wr = planes_type'(wr_bus);

    // Odd/even addressing steers even A0 to planes 0,2 and odd to 1,3.
    wire [3:0] plane_en = !odd_even ? 4'hf :
                          mem_req.a0 ? 4'ha : 4'h5;
    assign plane_we = mem_req.wr ? plane_en : 4'h0;

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire [31:0] rd_bus = plane_rd;
    // Plane choice; under odd/even, bit 0 comes from A0 instead.
    wire [1:0] rd_plane = odd_even ? {plane_read_r[1], mem_req.a0}
                                   : plane_read_r[1:0];
    wire [7:0] direct_rd = rd_bus[rd_plane*8 +: 8];
    logic [7:0] match;      // Colour compare result per pixel.

    // A pixel matches when every compared plane equals its reference bit.
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb++) begin : g_pix
            wire [3:0] pix = {rd_bus[24+gb], rd_bus[16+gb],
                              rd_bus[8+gb], rd_bus[gb]};
            assign match[gb] = ~|((pix ^ cmp_colour_r[3:0]) &
                                  cmp_ignore_r[3:0]);
        end
    endgenerate

    // Read result and latch load on every processor memory read.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_rdata <= 8'h00;
            latch_r   <= '0;
        end else if (mem_req.rd) begin
            mem_rdata <= read_cmp ? match : direct_rd;
            latch_r   <= plane_rd;
        end
    end

endmodule // gfx_unit
`default_nettype wire

// ===== dv/gfx_plane_model.sv
// Behavioural model of the four display memory planes at one address.
// Assumes gfx_unit drives plane_wr and plane_we combinationally.
`timescale 1ns/1ps
`default_nettype none
module gfx_plane_model #(
    parameter logic [31:0] INIT = 32'h3c_a5_0f_96  // Starting plane contents.
) (
    // Clock and reset.
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Plane port.
    input  wire gfx_pkg::planes_type plane_wr,
    input  wire logic [3:0]          plane_we,
    output gfx_pkg::planes_type      plane_rd
);
    import gfx_pkg::*;
    planes_type store_r;  // Stored bytes of all planes.
    // Reads are combinational so latches see the byte in the request cycle.
    assign plane_rd = store_r;
    // Each plane stores its byte only when its own enable is high.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            store_r <= INIT;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (plane_we[p]) store_r[8*p +: 8] <= plane_wr[8*p +: 8];
            end
        end
    end
endmodule // gfx_plane_model
`default_nettype wire

// ===== dv/gfx_unit_assertions.sv
// Port checker for gfx_unit; shadows a few registers from I/O writes.
// Assumes it is bound to gfx_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gfx_unit_assertions (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 io_wr,
    input wire logic                 io_rd,
    input wire logic [15:0]          io_addr,
    input wire logic [7:0]           io_wdata,
    input wire logic [7:0]           io_rdata,
    input wire gfx_pkg::mem_req_type mem_req,
    input wire logic [7:0]           mem_rdata,
    input wire gfx_pkg::planes_type  plane_rd,
    input wire gfx_pkg::planes_type  plane_wr,
    input wire logic [3:0]           plane_we,
    input wire logic                 shift_odd_even,
    input wire logic                 shift_256
);
    import gfx_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [3:0] idx_r;             // Shadow of the index.
    logic [7:0] ac_r, pr_r, bm_r;  // Shadows of access control, plane read, mask.
    planes_type lat_r;             // Shadow of the plane latches.
    wire dwr = io_wr && io_addr == DATA_PORT_ADDR;  // Data port write.
    // The shadows follow the same writes the unit takes.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {idx_r, ac_r, pr_r, bm_r, lat_r} <= '0;
        end else begin
            if (io_wr && io_addr == INDEX_PORT_ADDR) idx_r <= io_wdata[3:0];
            if (dwr && idx_r == IDX_ACCESS_CTL) ac_r <= io_wdata & MASK_AC;
            if (dwr && idx_r == IDX_PLANE_READ) pr_r <= io_wdata & MASK_PR;
            if (dwr && idx_r == IDX_BIT_MASK) bm_r <= io_wdata;
            if (mem_req.rd) lat_r <= plane_rd;
        end
    end
    property p_we_idle; !mem_req.wr |-> plane_we == 4'h0; endproperty
    a_we_idle: assert property (p_we_idle) else $error("plane enable without write");
    property p_we_all; mem_req.wr && !ac_r[4] |-> plane_we == 4'hf; endproperty
    a_we_all: assert property (p_we_all) else $error("plane enables wrong");
    property p_we_oe; mem_req.wr && ac_r[4] |-> plane_we == (mem_req.a0 ? 4'ha : 4'h5); endproperty
    a_we_oe: assert property (p_we_oe) else $error("odd even enables wrong");
    property p_mode1; mem_req.wr && ac_r[1:0] == WM_1 |-> plane_wr == lat_r; endproperty
    a_mode1: assert property (p_mode1) else $error("mode 1 data not latches");
    property p_mask;
        mem_req.wr && ac_r[1:0] != WM_1 |-> ((plane_wr ^ lat_r) & ~{4{bm_r}}) == 32'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("masked bit changed");
    property p_read0;
        mem_req.rd && !io_wr && ac_r[4:3] == 2'b00 |=> mem_rdata == lat_r[8*pr_r[1:0] +: 8];
    endproperty
    a_read0: assert property (p_read0) else $error("plane read wrong");
    property p_index;
        io_rd && !io_wr && io_addr == INDEX_PORT_ADDR |=> io_rdata == {4'h0, idx_r};
    endproperty
    a_index: assert property (p_index) else $error("index read wrong");
    property p_unmap;
        io_rd && io_addr != INDEX_PORT_ADDR && io_addr != DATA_PORT_ADDR |=> io_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_sh256; shift_256 == ac_r[SH256_BIT]; endproperty
    a_sh256: assert property (p_sh256) else $error("256 shift wrong");
    property p_shoe; shift_odd_even == (ac_r[SHOE_BIT] && !ac_r[SH256_BIT]); endproperty
    a_shoe: assert property (p_shoe) else $error("odd even shift wrong");
    c_mode1: cover property (mem_req.wr && ac_r[1:0] == WM_1);
    c_cmp: cover property (mem_req.rd && ac_r[3]);
    c_oe: cover property (mem_req.wr && ac_r[4]);
endmodule // gfx_unit_assertions
`default_nettype wire

// ===== dv/gfx_unit_test.sv
// Testbench for gfx_unit with a plane memory model and a bound checker.
// Assumes 10 MHz clk_sys and synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module gfx_unit_test;
    import gfx_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, shift_odd_even, shift_256;
    logic [15:0] io_addr = 16'h0;
    logic [7:0]  io_wdata = 8'h0, io_rdata, mem_rdata, e8, lr, bm, d;
    logic [3:0]  plane_we, w_we;
    mem_req_type mem_req = '0;
    planes_type  plane_rd, plane_wr, w_wr, shadow, ex;
    int error_cnt = 0, checked = 0;
    always #50 clk_sys = ~clk_sys;
    gfx_unit i_dut (.clk_sys(clk_sys), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .plane_rd(plane_rd), .plane_wr(plane_wr),
        .plane_we(plane_we), .shift_odd_even(shift_odd_even), .shift_256(shift_256));
    gfx_plane_model i_mem (.clk_sys(clk_sys), .rst(rst), .plane_wr(plane_wr),
        .plane_we(plane_we), .plane_rd(plane_rd));
    // Compares one value, counts it, and reports a mismatch.
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    // One I/O write, held for exactly one taking edge.
    task automatic io_w(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        {io_wr, io_addr, io_wdata} <= {1'b1, a, v};
        @(posedge clk_sys);
        io_wr <= 1'b0;
        #1;
    endtask
    // One I/O read; data is looked at after the taking edge.
    task automatic io_r(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        {io_rd, io_addr} <= {1'b1, a};
        @(posedge clk_sys);
        io_rd <= 1'b0;
        #1 chk("io_rdata", e, io_rdata);
    endtask
    // Selects a register, then writes it through the data port.
    task automatic reg_w(input logic [3:0] i, input logic [7:0] v);
        io_w(INDEX_PORT_ADDR, {4'h0, i});
        io_w(DATA_PORT_ADDR, v);
    endtask
    // One memory cycle; write outputs are captured inside the request cycle.
    task automatic mem(input logic r, w, a0, input logic [7:0] v);
        @(posedge clk_sys);
        mem_req <= '{rd: r, wr: w, a0: a0, data: v};
        #1 {w_we, w_wr} = {plane_we, plane_wr};
        @(posedge clk_sys);
        mem_req <= '0;
        #1;
    endtask
    // Write path worked out independently: rotate, fill, logic, then mask.
    function automatic planes_type ref_wr(input logic [7:0] ac, lr, fv, fe, bm, d,
                                          input planes_type l);
        logic [15:0] dd;
        logic [7:0]  r, v, m, t;
        planes_type  o;
        dd = {d, d} >> lr[2:0];
        r = dd[7:0];
        for (int p = 0; p < 4; p++) begin
            t = l[8*p +: 8];
            v = (ac[1:0] == 2'b10) ? {8{d[p]}} : (ac[1:0] == 2'b11 || fe[p]) ? {8{fv[p]}} : r;
            m = (ac[1:0] == 2'b11) ? (r & bm) : bm;
            case (lr[4:3])
                2'b01: v = v & t;
                2'b10: v = v | t;
                2'b11: v = v ^ t;
                default: v = v;
            endcase
            o[8*p +: 8] = (ac[1:0] == 2'b01) ? t : (v & m) | (t & ~m);
        end
        return o;
    endfunction
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (8000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        logic [3:0] ix [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
        logic [7:0] mk [9] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h00, 8'h0f, 8'hff};
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        shadow = 32'h3c_a5_0f_96;
        for (int i = 0; i < 9; i++) begin
            io_w(INDEX_PORT_ADDR, {4'h0, ix[i]});
            io_r(DATA_PORT_ADDR, REG_RESET);
            reg_w(ix[i], 8'hff);
            io_r(DATA_PORT_ADDR, mk[i]);
        end
        io_w(INDEX_PORT_ADDR, 8'hf5);
        io_r(INDEX_PORT_ADDR, 8'h05);
        io_r(16'h03cd, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            lr = {3'h0, 2'(i >> 2), 3'(i + 3)};
            bm = 8'hc3 ^ 8'(i * 17);
            d = 8'h5a ^ 8'(i * 29);
            reg_w(IDX_ACCESS_CTL, 8'(i & 3));
            reg_w(IDX_LOGIC_ROT, lr);
            reg_w(IDX_FILL_VALUE, 8'(i));
            reg_w(IDX_FILL_ENABLE, 8'(~i & 15));
            reg_w(IDX_BIT_MASK, bm);
            reg_w(IDX_PLANE_READ, 8'(i & 3));
            mem(1'b1, 1'b0, 1'b0, 8'h00);
            chk("mem_rdata", shadow[8*(i & 3) +: 8], mem_rdata);
            ex = ref_wr(8'(i & 3), lr, 8'(i), 8'(~i & 15), bm, d, shadow);
            mem(1'b0, 1'b1, 1'b0, d);
            chk("plane_wr", ex, w_wr);
            chk("plane_we", 4'hf, w_we);
            shadow = ex;
        end
        $display("test write modes done");
        reg_w(IDX_ACCESS_CTL, 8'h08);
        for (int k = 0; k < 2; k++) begin
            reg_w(IDX_CMP_COLOUR, 8'(k * 9 + 5));
            reg_w(IDX_CMP_IGNORE, k ? 8'h0f : 8'h06);
            for (int b = 0; b < 8; b++) begin
                e8[b] = 1'b1;
                for (int p = 0; p < 4; p++) begin
                    if ((k == 1 || p == 1 || p == 2) &&
                        shadow[8*p+b] != ((4'(k * 9 + 5) >> p) & 4'h1))
                        e8[b] = 1'b0;
                end
            end
            mem(1'b1, 1'b0, 1'b0, 8'h00);
            chk("compare", e8, mem_rdata);
        end
        $display("test compare done");
        reg_w(IDX_ACCESS_CTL, 8'h10);
        mem(1'b0, 1'b1, 1'b1, 8'h77);
        chk("odd plane_we", 4'ha, w_we);
        reg_w(IDX_PLANE_READ, 8'h03);
        mem(1'b1, 1'b0, 1'b0, 8'h00);
        chk("even read", shadow.p2, mem_rdata);
        reg_w(IDX_ACCESS_CTL, 8'h20);
        chk("shift pair", 2'b10, {shift_odd_even, shift_256});
        reg_w(IDX_ACCESS_CTL, 8'h60);
        chk("shift 256", 2'b01, {shift_odd_even, shift_256});
        $display("test odd even and shift done");
        print_verdict();
    end
endmodule // gfx_unit_test
bind gfx_unit gfx_unit_assertions i_chk (.clk_sys(clk_sys), .rst(rst), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .plane_rd(plane_rd), .plane_wr(plane_wr),
    .plane_we(plane_we), .shift_odd_even(shift_odd_even), .shift_256(shift_256));
`default_nettype wire
